// [hw/pin_mux_cfg.svh]
// Offsets, reset values, pin positions and masks of the shared pin function select
`ifndef PIN_MUX_CFG_SVH
`define PIN_MUX_CFG_SVH
`define CTRL_OFS 12'h000
`define PIN_LO_OFS 12'h004
`define PIN_HI_OFS 12'h008
`define CTRL_RESET 15'h1800
`define PCC_OUT_MASK 6'h2B
`define PIN_HW_VAL {32'h0021_0000, 16'h0000, 2'h0, `PCC_OUT_MASK}
`define DISP_MUX_MASK 24'h01_0103
`define DISP_D8 8
`define DISP_D16 16
`define LO_CAM_D 1:0
`define LO_EXTCLK0 2
`define LO_CLKIN 3
`define LO_DMA0 4
`define LO_SD_DAT2 6
`define LO_SD_DAT1 8
`define LO_DMA1 12
`define LO_SYNC0 16
`define LO_SD_CLK 17
`define LO_SD_DAT0 19
`define LO_SYNC1 21
`define LO_EXT23 23
`define LO_SD_DAT3 26
`define LO_SD_CMD 28
`define HI_DISP_D 1:0
`define HI_CAM_D 9:2
`define HI_DISP_D8 10
`define HI_DISP_D16 11
`define HI_CAM_LS 12
`define HI_CAM_CLK 14
`endif

// [hw/pin_mux_pkg.sv]
// Types shared by the shared pin function select block
`default_nettype none
package pin_mux_pkg;
  typedef struct packed {
    logic frequency_generator_3_src;
    logic ser1_ext_clk;
    logic sync1_ctrl1;
    logic sync1_ctrl0;
    logic dma1;
    logic dma0;
    logic [1:0] ext_clk;
    logic card1;
    logic card0;
    logic disp_clk;
    logic disp_data;
    logic pwm;
    logic cam_low;
    logic cam;
  } sel_s;
  typedef struct packed {
    logic [31:0] lo;
    logic [15:0] hi;
    logic [1:0] pwm;
    logic [5:0] pcc;
  } pin_s;
  typedef struct packed {
    logic [31:0] lo;
    logic [15:0] hi;
  } gpio_s;
  typedef struct packed {
    logic camera_line_sync;
    logic [1:0] display_pulse_out;
    logic [23:0] display_data_out;
    logic [1:0] general_clock_out;
    logic serial_ctrl0_sync1_out;
    logic serial_ctrl1_sync1_out;
    logic card0_clock_out;
    logic card1_clock_out;
    logic [1:0] card_cmd_out;
    logic [1:0] card_cmd_oe;
    logic [3:0] card0_dat_out;
    logic [3:0] card1_dat_out;
    logic [1:0] card_dat_oe;
    logic pccard_io_read_n;
    logic pccard_io_write_n;
    logic pccard_output_enable_n;
    logic pccard_write_enable_n;
  } alt_out_s;
  typedef struct packed {
    logic [9:0] camera_data_in;
    logic camera_pixel_clock_in;
    logic serial1_carrier_detect_n;
    logic serial1_ring_indicate_n;
    logic display_clock_source_in;
    logic display_clock_source_sel;
    logic external_dma_request_0;
    logic external_dma_request_1;
    logic serial_ctrl1_ext_clock_in;
    logic frequency_generator_3_clock;
    logic frequency_generator_3_sel;
    logic [1:0] card_cmd_in;
    logic [3:0] card0_dat_in;
    logic [3:0] card1_dat_in;
    logic pccard_wait_n;
    logic pccard_port16_select_n;
  } alt_in_s;
endpackage : pin_mux_pkg
`default_nettype wire

// [hw/pin_level_sync.sv]
// Two-flop synchroniser for pin levels
`timescale 1ns/100ps
`default_nettype none
module pin_level_sync #(
  parameter int W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;
  sync_s st_r;
  sync_s st_nxt;

  always_comb
  begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign q = st_r.s2;
endmodule : pin_level_sync
`default_nettype wire

// [hw/pin_hold.sv]
// Pin drive register with hardware reset, runtime reset and sleep hold states
`timescale 1ns/100ps
`default_nettype none
module pin_hold #(
  parameter int W = 8,
  parameter logic [W-1:0] HW_OUT = '0,
  parameter logic [W-1:0] HW_OE = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic runtime_reset,
  input wire logic sleep_active,
  input wire logic [W-1:0] d_out,
  input wire logic [W-1:0] d_oe,
  input wire logic [W-1:0] rt_out,
  input wire logic [W-1:0] rt_oe,
  output logic [W-1:0] q_out,
  output logic [W-1:0] q_oe
);
  typedef struct packed {
    logic [W-1:0] out;
    logic [W-1:0] oe;
  } hold_s;
  hold_s st_r;
  hold_s st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (runtime_reset)
    begin
      st_nxt.out = rt_out;
      st_nxt.oe = rt_oe;
    end
    else if (!sleep_active)
    begin
      st_nxt.out = d_out;
      st_nxt.oe = d_oe;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= {HW_OUT, HW_OE};
    else
      st_r <= st_nxt;
  end

  assign q_out = st_r.out;
  assign q_oe = st_r.oe;

  chk_sleep_keeps_pins: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_active && !runtime_reset ##1 sleep_active && !runtime_reset
      ##1 sleep_active && !runtime_reset
      |-> $stable(q_out) && $stable(q_oe) && q_out == $past(q_out, 2))
    else $error("pins moved during sleep");
  chk_runtime_load: assert property (@(posedge pclk) disable iff (!presetn)
    runtime_reset |=> q_out == $past(rt_out) && q_oe == $past(rt_oe))
    else $error("runtime reset pin state not applied");
endmodule : pin_hold
`default_nettype wire

// [hw/shared_pin_function_select.sv]
// Shared pin function select: APB control, pin mux, reset and sleep pin states
`timescale 1ns/100ps
`default_nettype none
`include "pin_mux_cfg.svh"
module shared_pin_function_select
  import pin_mux_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic runtime_reset,
  input wire logic sleep_active,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pin_s pin_in,
  output var pin_s pin_out,
  output var pin_s pin_oe,
  output logic [23:0] display_data_pins,
  input wire logic tck,
  input wire logic tdi,
  input wire logic tms,
  output logic tdo_out,
  output logic tdo_oe,
  input wire logic tap_tdo_core,
  output logic tap_tdi,
  output logic tap_tms,
  output logic tap_sample,
  input wire gpio_s gpio_out,
  input wire gpio_s gpio_oe,
  output var gpio_s gpio_in,
  input wire alt_out_s alt_out,
  output var alt_in_s alt_in
);
  typedef struct packed {
    sel_s sel;
    logic [31:0] prdata;
    alt_in_s alt_in;
    logic tck_prev;
    logic tdi;
    logic tms;
    logic sample;
    logic tdo;
    logic tdo_oe;
  } main_s;

  localparam alt_in_s ALT_IDLE = '{serial1_carrier_detect_n: 1'b1,
    serial1_ring_indicate_n: 1'b1, pccard_wait_n: 1'b1, pccard_port16_select_n: 1'b1,
    default: '0};
  localparam main_s MAIN_RESET = '{sel: sel_s'(`CTRL_RESET), alt_in: ALT_IDLE, default: '0};
  localparam int PW = $bits(pin_s);

  main_s st_r;
  main_s st_nxt;
  pin_s pq;
  logic [2:0] jq;
  pin_s po;
  pin_s pe;
  pin_s rt_o;
  pin_s rt_e;
  logic [31:0] rd;
  logic [15:0] wr;
  logic hit;
  logic tck_q;
  logic tck_rise;
  logic tck_fall;

  pin_level_sync #(.W(PW + 3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({pin_in, tck, tdi, tms}),
    .q({pq, jq})
  );

  assign tck_q = jq[2];
  assign tck_rise = tck_q && !st_r.tck_prev;
  assign tck_fall = !tck_q && st_r.tck_prev;
  assign hit = paddr == `CTRL_OFS || paddr == `PIN_LO_OFS || paddr == `PIN_HI_OFS;

  // Pin drive mux: lo and hi pins are general-purpose I/O unless a function is selected
  always_comb
  begin
    po = '0;
    pe = '0;
    po.lo = gpio_out.lo;
    pe.lo = gpio_oe.lo;
    po.hi = gpio_out.hi;
    pe.hi = gpio_oe.hi;
    if (st_r.sel.cam)
    begin
      pe.hi[`HI_CAM_D] = '0;
      pe.hi[`HI_CAM_CLK] = 1'b0;
      po.hi[`HI_CAM_LS] = alt_out.camera_line_sync;
      pe.hi[`HI_CAM_LS] = 1'b1;
    end
    if (st_r.sel.cam_low)
      pe.lo[`LO_CAM_D] = '0;
    po.pwm = st_r.sel.pwm ? alt_out.display_pulse_out : 2'h0;
    pe.pwm = {2{st_r.sel.pwm}};
    if (st_r.sel.disp_data)
    begin
      po.hi[`HI_DISP_D] = alt_out.display_data_out[1:0];
      po.hi[`HI_DISP_D8] = alt_out.display_data_out[`DISP_D8];
      po.hi[`HI_DISP_D16] = alt_out.display_data_out[`DISP_D16];
      pe.hi[`HI_DISP_D] = 2'h3;
      pe.hi[`HI_DISP_D8] = 1'b1;
      pe.hi[`HI_DISP_D16] = 1'b1;
    end
    for (int i = 0; i < 2; i++)
    begin
      if (st_r.sel.ext_clk[i])
      begin
        po.lo[`LO_EXTCLK0 + i] = alt_out.general_clock_out[i];
        pe.lo[`LO_EXTCLK0 + i] = 1'b1;
      end
    end
    // Display clock input takes pin 3 over the general clock output
    if (st_r.sel.disp_clk)
      pe.lo[`LO_CLKIN] = 1'b0;
    if (st_r.sel.dma0)
      pe.lo[`LO_DMA0] = 1'b0;
    if (st_r.sel.dma1)
      pe.lo[`LO_DMA1] = 1'b0;
    if (st_r.sel.sync1_ctrl0)
    begin
      po.lo[`LO_SYNC0] = alt_out.serial_ctrl0_sync1_out;
      pe.lo[`LO_SYNC0] = 1'b1;
    end
    if (st_r.sel.sync1_ctrl1)
    begin
      po.lo[`LO_SYNC1] = alt_out.serial_ctrl1_sync1_out;
      pe.lo[`LO_SYNC1] = 1'b1;
    end
    if (st_r.sel.card0)
    begin
      po.lo[`LO_SD_CLK] = alt_out.card0_clock_out;
      pe.lo[`LO_SD_CLK] = 1'b1;
      po.lo[`LO_SD_CMD] = alt_out.card_cmd_out[0];
      pe.lo[`LO_SD_CMD] = alt_out.card_cmd_oe[0];
      po.lo[`LO_SD_DAT0] = alt_out.card0_dat_out[0];
      po.lo[`LO_SD_DAT1] = alt_out.card0_dat_out[1];
      po.lo[`LO_SD_DAT2] = alt_out.card0_dat_out[2];
      po.lo[`LO_SD_DAT3] = alt_out.card0_dat_out[3];
      pe.lo[`LO_SD_DAT0] = alt_out.card_dat_oe[0];
      pe.lo[`LO_SD_DAT1] = alt_out.card_dat_oe[0];
      pe.lo[`LO_SD_DAT2] = alt_out.card_dat_oe[0];
      pe.lo[`LO_SD_DAT3] = alt_out.card_dat_oe[0];
    end
    if (st_r.sel.card1)
    begin
      po.pcc = {alt_out.card1_dat_out, alt_out.card_cmd_out[1], alt_out.card1_clock_out};
      pe.pcc = {{4{alt_out.card_dat_oe[1]}}, alt_out.card_cmd_oe[1], 1'b1};
    end
    else
    begin
      po.pcc = {alt_out.pccard_write_enable_n, 1'b0, alt_out.pccard_output_enable_n, 1'b0,
        alt_out.pccard_io_read_n, alt_out.pccard_io_write_n};
      pe.pcc = `PCC_OUT_MASK;
    end
  end

  // Pin state applied while runtime reset is held
  always_comb
  begin
    rt_o = `PIN_HW_VAL;
    rt_e = `PIN_HW_VAL;
    if (st_r.sel.card0)
    begin
      rt_o.lo[`LO_SD_CLK] = 1'b0;
      rt_e.lo[`LO_SD_CLK] = 1'b1;
    end
    if (st_r.sel.card1)
      rt_o.pcc[0] = 1'b0;
  end

  always_comb
  begin
    st_nxt = st_r;
    wr = {1'b0, st_r.sel};
    case (paddr)
      `CTRL_OFS: rd = {17'h0_0000, st_r.sel};
      `PIN_LO_OFS: rd = pq.lo;
      `PIN_HI_OFS: rd = {8'h00, pq.pcc, pq.pwm, pq.hi};
      default: rd = 32'h0000_0000;
    endcase
    if (psel && !penable)
      st_nxt.prdata = rd;
    if (pstrb[0])
      wr[7:0] = pwdata[7:0];
    if (pstrb[1])
      wr[15:8] = pwdata[15:8];
    if (runtime_reset)
      st_nxt.sel = sel_s'(`CTRL_RESET);
    else if (psel && penable && pwrite && paddr == `CTRL_OFS)
      st_nxt.sel = sel_s'(wr[14:0]);
    st_nxt.alt_in.camera_data_in = {st_r.sel.cam ? pq.hi[`HI_CAM_D] : 8'h00,
      st_r.sel.cam_low ? pq.lo[`LO_CAM_D] : 2'h0};
    st_nxt.alt_in.camera_pixel_clock_in = st_r.sel.cam && pq.hi[`HI_CAM_CLK];
    // Unowned modem inputs read inactive so the serial port sees no edges
    st_nxt.alt_in.serial1_carrier_detect_n = st_r.sel.pwm || pq.pwm[0];
    st_nxt.alt_in.serial1_ring_indicate_n = st_r.sel.pwm || pq.pwm[1];
    st_nxt.alt_in.display_clock_source_in = st_r.sel.disp_clk && pq.lo[`LO_CLKIN];
    st_nxt.alt_in.display_clock_source_sel = st_r.sel.disp_clk;
    st_nxt.alt_in.external_dma_request_0 = st_r.sel.dma0 && pq.lo[`LO_DMA0];
    st_nxt.alt_in.external_dma_request_1 = st_r.sel.dma1 && pq.lo[`LO_DMA1];
    st_nxt.alt_in.serial_ctrl1_ext_clock_in = st_r.sel.ser1_ext_clk && pq.lo[`LO_EXT23];
    st_nxt.alt_in.frequency_generator_3_clock = st_r.sel.frequency_generator_3_src && pq.lo[`LO_EXT23];
    st_nxt.alt_in.frequency_generator_3_sel = st_r.sel.frequency_generator_3_src;
    st_nxt.alt_in.card_cmd_in = {pq.pcc[1], pq.lo[`LO_SD_CMD]};
    st_nxt.alt_in.card0_dat_in = {pq.lo[`LO_SD_DAT3], pq.lo[`LO_SD_DAT2], pq.lo[`LO_SD_DAT1],
      pq.lo[`LO_SD_DAT0]};
    st_nxt.alt_in.card1_dat_in = pq.pcc[5:2];
    st_nxt.alt_in.pccard_wait_n = st_r.sel.card1 || pq.pcc[2];
    st_nxt.alt_in.pccard_port16_select_n = st_r.sel.card1 || pq.pcc[4];
    st_nxt.tck_prev = tck_q;
    st_nxt.sample = tck_rise;
    if (tck_rise)
    begin
      st_nxt.tdi = jq[1];
      st_nxt.tms = jq[0];
    end
    if (tck_fall && !sleep_active)
      st_nxt.tdo = tap_tdo_core;
    st_nxt.tdo_oe = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= MAIN_RESET;
    else
      st_r <= st_nxt;
  end

  pin_hold #(.W(PW), .HW_OUT(`PIN_HW_VAL), .HW_OE(`PIN_HW_VAL)) u_pins (
    .pclk(pclk),
    .presetn(presetn),
    .runtime_reset(runtime_reset),
    .sleep_active(sleep_active),
    .d_out(po),
    .d_oe(pe),
    .rt_out(rt_o),
    .rt_oe(rt_e),
    .q_out(pin_out),
    .q_oe(pin_oe)
  );

  // Dedicated display data pins; muxed bits leave on general pins instead
  pin_hold #(.W(24), .HW_OUT(24'h00_0000), .HW_OE(24'hFF_FFFF)) u_disp (
    .pclk(pclk),
    .presetn(presetn),
    .runtime_reset(runtime_reset),
    .sleep_active(sleep_active),
    .d_out(alt_out.display_data_out & ~`DISP_MUX_MASK),
    .d_oe(24'hFF_FFFF),
    .rt_out(24'h00_0000),
    .rt_oe(24'hFF_FFFF),
    .q_out(display_data_pins),
    .q_oe()
  );

  assign prdata = st_r.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign gpio_in = {pq.lo, pq.hi};
  assign alt_in = st_r.alt_in;
  assign tdo_out = st_r.tdo;
  assign tdo_oe = st_r.tdo_oe;
  assign tap_tdi = st_r.tdi;
  assign tap_tms = st_r.tms;
  assign tap_sample = st_r.sample;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence ctrl_full_write;
    psel && penable && pwrite && paddr == `CTRL_OFS && pstrb == 4'hF && !runtime_reset;
  endsequence
  sequence rt_then_run;
    runtime_reset ##1 !runtime_reset && !sleep_active;
  endsequence

  chk_cam_gpio_default: assert property (rt_then_run |=> !$past(st_r.sel.cam)
    && pin_oe.hi[`HI_CAM_CLK] == $past(gpio_oe.hi[`HI_CAM_CLK]))
    else $error("camera pins not general-purpose after runtime reset");
  chk_cam_low_input: assert property (st_r.sel.cam_low && !runtime_reset && !sleep_active
    |=> pin_oe.lo[`LO_CAM_D] == 2'h0)
    else $error("camera data pins 1:0 driven while selected");
  chk_pwm_serial_default: assert property (rt_then_run |=> pin_oe.pwm == 2'h0
    && pin_out.pwm == 2'h0)
    else $error("display pulse pins not serial inputs after reset");
  chk_disp_muxed_zero: assert property ((display_data_pins & `DISP_MUX_MASK) == 24'h00_0000)
    else $error("muxed display data driven on dedicated pins");
  chk_card0_clk_runtime: assert property (runtime_reset && st_r.sel.card0
    |=> pin_oe.lo[`LO_SD_CLK] && !pin_out.lo[`LO_SD_CLK])
    else $error("card clock not low during runtime reset");
  chk_pccard_default: assert property (runtime_reset ##1 runtime_reset
    |=> pin_oe.pcc == `PCC_OUT_MASK && !st_r.sel.card1)
    else $error("card 1 pins not PC-card after reset");
  chk_tap_rise_sample: assert property (tck_rise |=> st_r.sample
    && st_r.tdi == $past(jq[1]) && st_r.tms == $past(jq[0]))
    else $error("TAP inputs not taken on TCK rise");
  chk_tdo_fall_only: assert property (!(tck_fall && !sleep_active) |=> $stable(tdo_out))
    else $error("TDO changed away from TCK fall");
  chk_general_clock_out_default: assert property (runtime_reset |=> st_r.sel.ext_clk == 2'h0)
    else $error("general clock outputs selected after reset");
  chk_dma_gate: assert property (!st_r.sel.dma0 |=> !alt_in.external_dma_request_0)
    else $error("DMA request 0 seen while not selected");
  chk_sync_high: assert property (runtime_reset |=> pin_out.lo[`LO_SYNC0]
    && pin_oe.lo[`LO_SYNC1] && pin_out.lo[`LO_SYNC1])
    else $error("sync-1 pins not driven high in reset");
  chk_pin23_gate: assert property (!st_r.sel.ser1_ext_clk
    |=> !alt_in.serial_ctrl1_ext_clock_in)
    else $error("serial external clock passed while unselected");
  chk_ctrl_write: assert property (ctrl_full_write |=> st_r.sel == sel_s'($past(pwdata[14:0])))
    else $error("control write not stored");
  chk_ctrl_hold: assert property (!(psel && penable && pwrite) && !runtime_reset
    |=> $stable(st_r.sel))
    else $error("function select changed without a write");
endmodule : shared_pin_function_select
`default_nettype wire

// [test/pad_board.sv]
// Board model: resolves each shared pad from the block's drive and the board's own level
`timescale 1ns/100ps
`default_nettype none
module pad_board
  import pin_mux_pkg::*;
(
  input wire pin_s pin_out,
  input wire pin_s pin_oe,
  input wire pin_s ext,
  output var pin_s pin_in
);
  // A driven pad shows the block's value; an undriven one shows what the board puts on it
  assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule : pad_board
`default_nettype wire

// [test/tb_shared_pin_function_select.sv]
// Testbench for the shared pin function select block
`timescale 1ns/100ps
`default_nettype none
`include "pin_mux_cfg.svh"
module tb_shared_pin_function_select
  import pin_mux_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn, runtime_reset, sleep_active, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [23:0] display_data_pins;
  logic tck, tdi, tms, tdo_out, tdo_oe, tap_tdo_core, tap_tdi, tap_tms, tap_sample;
  pin_s pin_in, pin_out, pin_oe, board_ext, save;
  gpio_s gpio_out, gpio_oe, gpio_in;
  alt_out_s alt_out;
  alt_in_s alt_in;
  int errors = 0;
  int compares = 0;
  always #2 pclk = ~pclk;
  shared_pin_function_select u_dut (.pclk(pclk), .presetn(presetn),
    .runtime_reset(runtime_reset), .sleep_active(sleep_active), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .display_data_pins(display_data_pins),
    .tck(tck), .tdi(tdi), .tms(tms), .tdo_out(tdo_out), .tdo_oe(tdo_oe),
    .tap_tdo_core(tap_tdo_core), .tap_tdi(tap_tdi), .tap_tms(tap_tms),
    .tap_sample(tap_sample), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
    .alt_out(alt_out), .alt_in(alt_in));
  pad_board u_board (.pin_out(pin_out), .pin_oe(pin_oe), .ext(board_ext), .pin_in(pin_in));
  task wrap_up;
    if (errors == 0 && compares > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  task chk(input string n, input logic [55:0] s, input logic [55:0] x);
    compares++;
    if (s !== x)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : cyc
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
           output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk("prdata", r, x);
    chk("pslverr", e, xe);
  endtask : rd
  task wr(input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, `CTRL_OFS, d, r, e);
    chk("write_err", e, 1'b0);
    chk("pready", pready, 1'b1);
  endtask : wr
  initial
  begin
    repeat (5000) @(posedge pclk);
    errors++;
    wrap_up();
  end
  initial
  begin
    presetn = 1'b0;
    runtime_reset = 1'b0;
    sleep_active = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    {tck, tdi, tms, tap_tdo_core} = 4'h0;
    gpio_out = gpio_s'(48'hC3A5_9E1F_6B2D);
    gpio_oe = gpio_s'(48'hFF7F_FFFF_FFFF);
    alt_out = alt_out_s'({17{3'b101}});
    board_ext = pin_s'(56'h963C_5AE1_874D_2B);
    cyc(10);
    chk("hw_oe", pin_oe, `PIN_HW_VAL);
    chk("hw_out", pin_out, `PIN_HW_VAL);
    chk("hw_disp", display_data_pins, 24'h00_0000);
    chk("hw_tdo_oe", tdo_oe, 1'b0);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`CTRL_OFS, 32'h0000_1800, 1'b0);
    rd(12'h00C, 32'h0000_0000, 1'b1);
    cyc(4);
    chk("def_hi", pin_out.hi, gpio_out.hi);
    chk("def_hi_oe", pin_oe.hi, gpio_oe.hi);
    chk("def_ck", pin_out.lo[3:2], gpio_out.lo[3:2]);
    chk("def_17", pin_out.lo[17], gpio_out.lo[17]);
    chk("def_sync", {pin_out.lo[21], pin_out.lo[16]}, {alt_out.serial_ctrl1_sync1_out,
        alt_out.serial_ctrl0_sync1_out});
    chk("def_sync_oe", {pin_oe.lo[21], pin_oe.lo[16]}, 2'b11);
    chk("def_pcc", pin_out.pcc[0], alt_out.pccard_io_write_n);
    chk("def_pwm_oe", pin_oe.pwm, 2'b00);
    chk("def_dcd", alt_in.serial1_carrier_detect_n, pin_in.pwm[0]);
    chk("def_cam", alt_in.camera_data_in, 10'h000);
    chk("def_dma", alt_in.external_dma_request_0, 1'b0);
    chk("gpio_in", gpio_in, {pin_in.lo, pin_in.hi});
    rd(`PIN_LO_OFS, pin_in.lo, 1'b0);
    rd(`PIN_HI_OFS, {8'h00, pin_in.pcc, pin_in.pwm, pin_in.hi}, 1'b0);
    wr(32'h0000_3E7F);
    rd(`CTRL_OFS, 32'h0000_3E7F, 1'b0);
    cyc(4);
    chk("cam", alt_in.camera_data_in, {pin_in.hi[9:2], pin_in.lo[1:0]});
    chk("disp", pin_out.hi[1:0], alt_out.display_data_out[1:0]);
    chk("disp_oe", pin_oe.hi[1:0], 2'b11);
    chk("pwm", pin_out.pwm, alt_out.display_pulse_out);
    chk("pwm_oe", pin_oe.pwm, 2'b11);
    chk("pwm_modem", {alt_in.serial1_ring_indicate_n, alt_in.serial1_carrier_detect_n}, 2'b11);
    chk("dclk", alt_in.display_clock_source_in, pin_in.lo[3]);
    chk("card0", pin_out.lo[17], alt_out.card0_clock_out);
    chk("card1", pin_out.pcc[0], alt_out.card1_clock_out);
    chk("dma", {alt_in.external_dma_request_1, alt_in.external_dma_request_0},
        {pin_in.lo[12], pin_in.lo[4]});
    chk("ser_ck", alt_in.serial_ctrl1_ext_clock_in, pin_in.lo[23]);
    @(posedge pclk);
    sleep_active <= 1'b1;
    cyc(2);
    save = pin_out;
    @(posedge pclk);
    alt_out <= ~alt_out;
    gpio_out <= ~gpio_out;
    cyc(4);
    chk("sleep", pin_out, save);
    @(posedge pclk);
    sleep_active <= 1'b0;
    cyc(2);
    chk("wake", pin_out.hi[1:0], alt_out.display_data_out[1:0]);
    @(posedge pclk);
    runtime_reset <= 1'b1;
    cyc(1);
    chk("rt_card", {pin_out.lo[17], pin_oe.lo[17]}, 2'b01);
    chk("rt_pwm", pin_out.pwm, 2'b00);
    cyc(1);
    chk("rt_disp", display_data_pins, 24'h00_0000);
    @(posedge pclk);
    runtime_reset <= 1'b0;
    rd(`CTRL_OFS, 32'h0000_1800, 1'b0);
    wr(32'h0000_4180);
    cyc(4);
    chk("gclk", pin_out.lo[3:2], alt_out.general_clock_out);
    chk("frequency_generator_3", alt_in.frequency_generator_3_clock, pin_in.lo[23]);
    chk("nosync", pin_out.lo[16], gpio_out.lo[16]);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge pclk);
      tck <= 1'b1;
      tdi <= i[0];
      tms <= ~i[0];
      tap_tdo_core <= ~i[0];
      repeat (8)
      begin
        cyc(1);
        if (tap_sample === 1'b1) break;
      end
      chk("tap_in", {tap_sample, tap_tdi, tap_tms}, {1'b1, i[0], ~i[0]});
      @(posedge pclk);
      tck <= 1'b0;
      cyc(3);
      chk("tdo", {tdo_out, tdo_oe}, {~i[0], 1'b1});
      cyc(3);
    end
    wrap_up();
  end
endmodule : tb_shared_pin_function_select
`default_nettype wire
